// ==== src/ioexp_top.sv ====
`timescale 1ns/1ps
module ioexp_top
  import ioexp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic ext_reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic port_line_open_drain_in,
  output logic port_line_open_drain_out,
  output logic port_line_open_drain_oe,
  input wire logic [7:1] port_lines_in,
  output logic [7:1] port_lines_out,
  output logic [7:1] port_lines_oe
);

  // ----------------------------------------
  // Reset in both domains
  // ----------------------------------------
  logic any_rst;
  logic sys_rst;
  logic link_rst;

  // Pin reset and power-on reset share one path
  assign any_rst = reset | ~ext_reset_n;

  ioexp_reset_sync u_sys_rst (
    .clk(clk),
    .async_rst(any_rst),
    .sync_rst(sys_rst)
  );

  ioexp_reset_sync u_link_rst (
    .clk(link_clk),
    .async_rst(any_rst),
    .sync_rst(link_rst)
  );

  // ----------------------------------------
  // Link side: filtered bus lines
  // ----------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_d;
  logic sda_d;

  ioexp_glitch_filter u_scl_filt (
    .clk(link_clk),
    .reset(link_rst),
    .raw(scl_in),
    .clean(scl_f)
  );

  ioexp_glitch_filter u_sda_filt (
    .clk(link_clk),
    .reset(link_rst),
    .raw(sda_in),
    .clean(sda_f)
  );

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_cond = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_cond = scl_f & scl_d & ~sda_d & sda_f;

  // ----------------------------------------
  // Link side: address straps
  // ----------------------------------------
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic [2:0] strap_held;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else begin
      strap_meta <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
      strap_sync <= strap_meta;
    end
  end

  // Straps may not move inside a frame, so take them at start
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      strap_held <= 3'h0;
    end else if (start_cond) begin
      strap_held <= strap_sync;
    end
  end

  // ----------------------------------------
  // Link side: crossings from the register side
  // ----------------------------------------
  logic rd_req_tgl;
  logic rd_ack_tgl;
  logic rd_ack_meta;
  logic rd_ack_sync;
  logic snap_ready;
  logic [7:0] snap [4];

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rd_ack_meta <= 1'b0;
      rd_ack_sync <= 1'b0;
    end else begin
      rd_ack_meta <= rd_ack_tgl;
      rd_ack_sync <= rd_ack_meta;
    end
  end

  assign snap_ready = (rd_ack_sync == rd_req_tgl);

  // ----------------------------------------
  // Link side: serial state machine
  // ----------------------------------------
  ioexp_state_e state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic byte_done;
  logic rw;
  logic [1:0] cmd_sel;
  logic wr_tgl;
  logic [1:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;

  // Empty snapshot reads as released bus
  assign rd_byte = snap_ready ? snap[cmd_sel] : 8'hff;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      byte_done <= 1'b0;
      rw <= 1'b0;
      cmd_sel <= CMD_INPUT;
      sda_oe <= 1'b0;
      wr_tgl <= 1'b0;
      wr_idx <= CMD_INPUT;
      wr_data <= 8'h00;
      rd_req_tgl <= 1'b0;
    end else if (start_cond) begin
      state <= ST_ADDR;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_f};
            bit_cnt <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == 3'h7);
          end else if (scl_fall && byte_done) begin
            byte_done <= 1'b0;
            sda_oe <= 1'b1;
            if (state == ST_ADDR) begin
              if (shift[7:1] == {ADDR_FIXED, strap_held}) begin
                rw <= shift[0];
                state <= ST_AACK;
                if (shift[0]) begin
                  rd_req_tgl <= ~rd_req_tgl;
                end
              end else begin
                // Not ours: stay off the bus until next start
                sda_oe <= 1'b0;
                state <= ST_IDLE;
              end
            end else if (state == ST_CMD) begin
              cmd_sel <= shift[1:0];
              state <= ST_CACK;
            end else begin
              wr_idx <= cmd_sel;
              wr_data <= shift;
              wr_tgl <= ~wr_tgl;
              state <= ST_WACK;
            end
          end
        end
        ST_AACK, ST_CACK, ST_WACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (state == ST_AACK && rw) begin
              shift <= rd_byte;
              sda_oe <= ~rd_byte[7];
              state <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state <= (state == ST_AACK) ? ST_CMD : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            // Master acknowledge slot: released, sampled on rise
            if (scl_rise && sda_f) begin
              state <= ST_IDLE;
              byte_done <= 1'b0;
            end else if (scl_fall) begin
              byte_done <= 1'b0;
              bit_cnt <= 3'h0;
              shift <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end
          end else if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              sda_oe <= 1'b0;
              byte_done <= 1'b1;
              rd_req_tgl <= ~rd_req_tgl;
            end else begin
              shift <= {shift[6:0], 1'b0};
              sda_oe <= ~shift[6];
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Bus data pin only ever pulls low
  assign sda_out = 1'b0;

  // ----------------------------------------
  // Register side: crossings from the link
  // ----------------------------------------
  logic wr_meta;
  logic wr_sync;
  logic wr_seen;
  logic rd_meta;
  logic rd_sync;
  logic rd_seen;
  logic wr_pulse;
  logic rd_pulse;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_meta <= 1'b0;
      wr_sync <= 1'b0;
      wr_seen <= 1'b0;
      rd_meta <= 1'b0;
      rd_sync <= 1'b0;
      rd_seen <= 1'b0;
    end else begin
      wr_meta <= wr_tgl;
      wr_sync <= wr_meta;
      wr_seen <= wr_sync;
      rd_meta <= rd_req_tgl;
      rd_sync <= rd_meta;
      rd_seen <= rd_sync;
    end
  end

  assign wr_pulse = wr_sync ^ wr_seen;
  assign rd_pulse = rd_sync ^ rd_seen;

  // ----------------------------------------
  // Register side: register file
  // ----------------------------------------
  logic [7:0] out_reg;
  logic [7:0] pol_reg;
  logic [7:0] dir_reg;
  logic [7:0] inp_reg;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;

  // Link side holds wr_idx and wr_data steady long before the pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg <= OUT_RESET;
      pol_reg <= POL_RESET;
      dir_reg <= DIR_RESET;
    end else if (wr_pulse) begin
      unique case (wr_idx)
        CMD_INPUT: begin
          out_reg <= out_reg;
        end
        CMD_OUTPUT: begin
          out_reg <= wr_data;
        end
        CMD_POLARITY: begin
          pol_reg <= wr_data;
        end
        CMD_DIRECTION: begin
          dir_reg <= wr_data;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      inp_reg <= INP_RESET;
    end else begin
      pin_meta <= {port_lines_in, port_line_open_drain_in};
      pin_sync <= pin_meta;
      // Pin level inverted where pol_reg is set, whatever the direction
      inp_reg <= pin_sync ^ pol_reg;
    end
  end

  // Snapshot stays frozen between requests, so the link reads it safely
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap[CMD_INPUT] <= INP_RESET;
      snap[CMD_OUTPUT] <= OUT_RESET;
      snap[CMD_POLARITY] <= POL_RESET;
      snap[CMD_DIRECTION] <= DIR_RESET;
      rd_ack_tgl <= 1'b0;
    end else if (rd_pulse) begin
      snap[CMD_INPUT] <= inp_reg;
      snap[CMD_OUTPUT] <= out_reg;
      snap[CMD_POLARITY] <= pol_reg;
      snap[CMD_DIRECTION] <= dir_reg;
      rd_ack_tgl <= rd_sync;
    end
  end

  // ----------------------------------------
  // Register side: pin drivers
  // ----------------------------------------
  // Enables reset low so nothing pulses out at power-up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_line_open_drain_oe <= 1'b0;
    end else begin
      port_line_open_drain_oe <= ~dir_reg[0] & ~out_reg[0];
    end
  end

  assign port_line_open_drain_out = 1'b0;

  genvar gi;
  generate
    for (gi = 1; gi < NUM_LINES; gi++) begin : g_push_pull
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          port_lines_oe[gi] <= 1'b0;
          port_lines_out[gi] <= 1'b0;
        end else begin
          port_lines_oe[gi] <= ~dir_reg[gi];
          port_lines_out[gi] <= out_reg[gi];
        end
      end
    end
  endgenerate

endmodule // ioexp_top

// ==== src/ioexp_pkg.sv ====
// ----------------------------------------
// Shared constants
// ----------------------------------------
package ioexp_pkg;

  localparam int unsigned NUM_LINES = 8;

  // Register values after reset
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] POL_RESET = 8'hf0;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] INP_RESET = 8'h00;

  // Fixed upper part of the seven-bit slave address
  localparam logic [3:0] ADDR_FIXED = 4'h3;

  // Command byte register selects
  localparam logic [1:0] CMD_INPUT = 2'h0;
  localparam logic [1:0] CMD_OUTPUT = 2'h1;
  localparam logic [1:0] CMD_POLARITY = 2'h2;
  localparam logic [1:0] CMD_DIRECTION = 2'h3;

  // Glitch filter timing on the link clock
  localparam int unsigned LINK_CLK_NS = 80;
  localparam int unsigned GLITCH_NS = 50;
  localparam int unsigned GLITCH_CYC_RAW = (GLITCH_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam logic [2:0] GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 3'h1 : 3'(GLITCH_CYC_RAW);

  // Serial state machine
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_AACK  = 8'h04,
    ST_CMD   = 8'h08,
    ST_CACK  = 8'h10,
    ST_WDATA = 8'h20,
    ST_WACK  = 8'h40,
    ST_RDATA = 8'h80
  } ioexp_state_e;

endpackage

// ==== src/ioexp_reset_sync.sv ====
`timescale 1ns/1ps
module ioexp_reset_sync (
  input wire logic clk,
  input wire logic async_rst,
  output logic sync_rst
);

  logic stage;

  // Assert at once, release on a clock edge
  always_ff @(posedge clk or posedge async_rst) begin
    if (async_rst) begin
      stage <= 1'b1;
      sync_rst <= 1'b1;
    end else begin
      stage <= 1'b0;
      sync_rst <= stage;
    end
  end

endmodule // ioexp_reset_sync

// ==== src/ioexp_glitch_filter.sv ====
`timescale 1ns/1ps
module ioexp_glitch_filter
  import ioexp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic raw,
  output logic clean
);

  logic meta;
  logic sync;
  logic [2:0] cnt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  // Change only after the level has stood long enough
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 3'h0;
      clean <= 1'b1;
    end else if (sync == clean) begin
      cnt <= 3'h0;
    end else if (cnt >= GLITCH_CYC) begin
      cnt <= 3'h0;
      clean <= sync;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

endmodule // ioexp_glitch_filter

// ==== sim/ioexp_properties.sv ====
`timescale 1ns/1ps
// ---
// Port checks
// ---
module ioexp_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic ext_reset_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic port_line_open_drain_out,
  input wire logic port_line_open_drain_oe,
  input wire logic [7:1] port_lines_out,
  input wire logic [7:1] port_lines_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Time since scl moved; writes may only land shortly after a bus edge
  logic scl_q;
  logic [5:0] quiet;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      quiet <= 6'h3f;
    end else begin
      scl_q <= scl_in;
      if (scl_in != scl_q) quiet <= 6'h00;
      else if (quiet != 6'h3f) quiet <= quiet + 6'h01;
    end
  end
  property p_pin_rst;
    !ext_reset_n |-> port_lines_oe == 7'h00 && !port_line_open_drain_oe && port_lines_out == 7'h00;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("line driven in reset");
  property p_pin_rst_bus;
    !ext_reset_n |-> !sda_oe;
  endproperty
  a_pin_rst_bus: assert property (p_pin_rst_bus) else $error("bus held in reset");
  property p_por_in;
    $fell(reset) |-> (port_lines_oe == 7'h00 && !port_line_open_drain_oe) [*3];
  endproperty
  a_por_in: assert property (p_por_in) else $error("drive after power reset");
  property p_pin_rel_in;
    $rose(ext_reset_n) |-> (port_lines_oe == 7'h00 && !port_line_open_drain_oe) [*3];
  endproperty
  a_pin_rel_in: assert property (p_pin_rel_in) else $error("drive after reset pin");
  property p_od_low;
    port_line_open_drain_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("line 0 drives high");
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("bus data drives high");
  property p_hold;
    ext_reset_n && $changed({port_lines_oe, port_lines_out, port_line_open_drain_oe})
      |-> quiet < 6'h1e;
  endproperty
  a_hold: assert property (p_hold) else $error("pins moved with bus idle");
  property p_filter;
    ext_reset_n && $changed(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2) && !$past(scl_in, 3);
  endproperty
  a_filter: assert property (p_filter) else $error("bus data moved early");
  c_ack: cover property ($rose(sda_oe));
  c_od_drive: cover property ($rose(port_line_open_drain_oe));
  c_pin_rst: cover property ($fell(ext_reset_n));
endmodule // ioexp_properties

bind ioexp_top ioexp_properties u_props (.clk(clk), .reset(reset), .ext_reset_n(ext_reset_n),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .port_line_open_drain_out(port_line_open_drain_out),
  .port_line_open_drain_oe(port_line_open_drain_oe),
  .port_lines_out(port_lines_out), .port_lines_oe(port_lines_oe));

// ==== sim/ioexp_bus_master.sv ====
`timescale 1ns/1ps
// ---
// Two-wire bus master
// ---
module ioexp_bus_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda,
  input wire logic glitch
);
  // Quarter bit; keeps scl low for 1.4 us
  localparam int Q = 700;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    // Short scl pulse in the low phase, far below the filter span
    if (glitch) begin
      #300 scl = 1'b1;
      #30 scl = 1'b0;
      #370;
    end else begin
      #Q;
    end
    scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] r,
                       output logic ack);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], t);
      r[i] = t;
    end
    // Master acks a read byte only when it wants another
    bit_io(~mack, t);
    ack = !t;
  endtask
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [7:0] v,
                      input logic rd, output logic [7:0] r, output logic [7:0] r2,
                      output logic ok);
    logic k;
    start();
    xbyte({a, 1'b0}, 1'b0, r, ok);
    xbyte(c, 1'b0, r, k);
    if (rd) begin
      start();
      xbyte({a, 1'b1}, 1'b0, r, k);
      // Second byte comes from a fresh snapshot of the same register
      xbyte(8'hff, 1'b1, r, k);
      xbyte(8'hff, 1'b0, r2, k);
    end else begin
      xbyte(v, 1'b0, r, k);
      r2 = r;
    end
    stop();
  endtask
endmodule // ioexp_bus_master

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
// ---
// Self-checking bench
// ---
module testbench;
  import ioexp_pkg::*;
  logic clk, reset, link_clk, ext_reset_n, od_ext, scl, sda_m, sda_oe, sda_out, od_out, od_oe;
  logic glitch_on;
  logic [2:0] strap;
  logic [7:1] ext_lines, l_out, l_oe;
  logic [7:0] dir, outv, pol;
  int errors, cmp_count, cycles, seed;
  // Pull-up on bus data; line 0 reads od_ext when released
  wire sda = sda_m & ~sda_oe;
  wire od_pin = od_oe ? 1'b0 : od_ext;
  wire [7:1] l_pin = (l_oe & l_out) | (~l_oe & ext_lines);
  ioexp_top uut (.clk(clk), .reset(reset), .link_clk(link_clk), .ext_reset_n(ext_reset_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .port_line_open_drain_in(od_pin), .port_line_open_drain_out(od_out),
    .port_line_open_drain_oe(od_oe), .port_lines_in(l_pin), .port_lines_out(l_out),
    .port_lines_oe(l_oe));
  ioexp_bus_master mst (.scl(scl), .sda_drv(sda_m), .sda(sda), .glitch(glitch_on));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("[ERR] timeout expected done seen running");
      test_done();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] exp_pins();
    return {(~dir[7:1] & outv[7:1]) | (dir[7:1] & ext_lines), (dir[0] | outv[0]) & od_ext};
  endfunction
  task automatic pins_chk();
    chk("oe", {~dir[7:1], ~dir[0] & ~outv[0]}, {l_oe, od_oe});
    chk("pins", exp_pins(), {l_pin, od_pin});
  endtask
  // Reads compare against v, writes send v
  task automatic acc(input logic [1:0] c, input logic [7:0] v, input logic rd, input string n);
    logic [7:0] r;
    logic [7:0] r2;
    logic k;
    mst.xfer({ADDR_FIXED, strap}, {6'h00, c}, v, rd, r, r2, k);
    chk("ack", 8'h01, {7'h00, k});
    if (rd) chk(n, v, r);
    if (rd) chk({n, "_again"}, v, r2);
  endtask
  initial begin
    logic [7:0] r;
    logic k;
    seed = 32'h663a;
    glitch_on = 1'b0;
    reset = 1'b1;
    ext_reset_n = 1'b1;
    strap = 3'h0;
    od_ext = 1'b1;
    ext_lines = 7'h00;
    dir = DIR_RESET;
    outv = OUT_RESET;
    pol = POL_RESET;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (20) @(negedge clk);
    pins_chk();
    acc(CMD_OUTPUT, OUT_RESET, 1'b1, "out_reg");
    acc(CMD_POLARITY, POL_RESET, 1'b1, "pol_reg");
    acc(CMD_DIRECTION, DIR_RESET, 1'b1, "dir_reg");
    $display("done: reset defaults");
    for (int it = 0; it < 3; it++) begin
      @(negedge clk);
      glitch_on = (it == 1);
      strap = 3'($random(seed));
      ext_lines = 7'($random(seed));
      od_ext = 1'($random(seed));
      outv = 8'($random(seed));
      pol = 8'($random(seed));
      dir = 8'($random(seed));
      // First pass: every line an output, line 0 pulled low
      if (it == 0) dir = 8'h00;
      if (it == 0) outv = 8'hfe;
      acc(CMD_OUTPUT, outv, 1'b0, "");
      acc(CMD_POLARITY, pol, 1'b0, "");
      acc(CMD_DIRECTION, dir, 1'b0, "");
      repeat (10) @(negedge clk);
      pins_chk();
      acc(CMD_INPUT, exp_pins() ^ pol, 1'b1, "in_reg");
      acc(CMD_OUTPUT, outv, 1'b1, "out_reg");
      pins_chk();
      $display("done: random config %0d", it);
    end
    for (int j = 0; j < 2; j++) begin
      mst.xfer(j ? {4'h2, strap} : {ADDR_FIXED, strap ^ 3'h1}, 8'h03, 8'hff, 1'b0,
               r, r, k);
      chk("foreign_ack", 8'h00, {7'h00, k});
    end
    acc(CMD_INPUT, 8'h5a, 1'b0, "");
    repeat (10) @(negedge clk);
    pins_chk();
    acc(CMD_INPUT, exp_pins() ^ pol, 1'b1, "in_reg");
    $display("done: foreign address and input write");
    ext_reset_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("oe_in_reset", 8'h00, {l_oe, od_oe});
    ext_reset_n = 1'b1;
    dir = DIR_RESET;
    outv = OUT_RESET;
    repeat (20) @(negedge clk);
    pins_chk();
    acc(CMD_DIRECTION, DIR_RESET, 1'b1, "dir_reg");
    acc(CMD_POLARITY, POL_RESET, 1'b1, "pol_reg");
    acc(CMD_OUTPUT, OUT_RESET, 1'b1, "out_reg");
    $display("done: reset pin");
    test_done();
  end
endmodule // testbench
